// *** sbrs_top.sv ***
// Serial port baud generator and receive status/control with AXI4-Lite registers
//
// Contract
// - In 9-bit async reception with address detect on, only frames whose ninth bit is one are kept.
// - With address detect off every frame is kept and, in 9-bit mode, its ninth bit stored as received.
// - In 8-bit async reception the address detect setting changes nothing.
// - One 8-bit rate timer serves both the async and the sync modes.
// - The rate timer runs all the time with a period set by the divisor register.
// - The high speed select picks the multiplier in async mode and is ignored in sync mode.
// - Any divisor write with byte lane 0 strobed clears the rate timer at once.
// - Bit rate is clock over prescale times divisor plus one, prescale 64, 16 or 4.
// - Unimplemented bits read as zero.
`timescale 1ns/1ps
module sbrs_top
    import sbrs_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,
    parameter int FIFO_DEPTH = SBRS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Completed frames from the receive shifter
    input wire logic frame_valid,
    output logic frame_ready,
    input wire logic [8:0] rx_shift_register,
    input wire logic frame_stop_bit,
    // Status toward the serial datapath
    output logic baud_tick,
    output logic port_enable,
    output logic sync_mode,
    output logic nine_bit_receive_select,
    output logic receive_active
);
    // Software-visible control state
    logic [7:0] rcv_ctrl_q;
    logic [7:0] baud_divisor_q;
    logic [7:0] xmt_ctrl_q;
    logic overrun_error_flag_q;
    logic framing_error_flag_q;
    logic rx_ninth_bit_q;

    // Bus state
    logic aw_held_q;
    logic [ADDR_WIDTH-1:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic do_write;
    logic do_read;
    logic wr_lane0;
    logic divisor_write;

    // Control fields
    logic addr_detect_enable;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic clock_source_master;
    logic high_speed_select;
    logic rx_enabled;

    // Frame path
    logic frame_keep;
    logic frame_take;
    logic frame_overrun;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [SBRS_ENTRY_WIDTH-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SBRS_ENTRY_WIDTH-1:0] rx_data_buffer;

    // Address match on the word, ignoring byte offset bits
    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] reg_addr);
        return a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(reg_addr[7:2]);
    endfunction

    function automatic logic addr_known(input logic [ADDR_WIDTH-1:0] a);
        return addr_is(a, SBRS_RCV_STAT_CTRL_ADDR) || addr_is(a, SBRS_BAUD_DIVISOR_ADDR)
            || addr_is(a, SBRS_XMT_STAT_CTRL_ADDR) || addr_is(a, SBRS_RX_DATA_BUFFER_ADDR);
    endfunction

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    // Registers are 8 bits wide, so only the low byte lane carries data
    assign wr_lane0 = do_write && w_strb_q[0];
    assign divisor_write = wr_lane0 && addr_is(aw_addr_q, SBRS_BAUD_DIVISOR_ADDR);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= SBRS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_known(aw_addr_q) ? SBRS_RESP_OKAY : SBRS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rcv_ctrl_q <= SBRS_RCV_STAT_CTRL_RESET;
        end else begin
            if (wr_lane0 && addr_is(aw_addr_q, SBRS_RCV_STAT_CTRL_ADDR)) begin
                rcv_ctrl_q <= w_data_q[7:0] & SBRS_RCS_WRITE_MASK;
            end
            // Single receive ends itself once a sync frame is taken
            if (frame_take && sync_mode && !continuous_receive_enable) begin
                rcv_ctrl_q[SBRS_RCS_SINGLE_RX] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            baud_divisor_q <= SBRS_BAUD_DIVISOR_RESET;
        end else if (divisor_write) begin
            baud_divisor_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xmt_ctrl_q <= SBRS_XMT_STAT_CTRL_RESET;
        end else if (wr_lane0 && addr_is(aw_addr_q, SBRS_XMT_STAT_CTRL_ADDR)) begin
            // No transmitter here, so the shift register always reads empty
            xmt_ctrl_q <= (w_data_q[7:0] & SBRS_TCS_WRITE_MASK) | SBRS_XMT_STAT_CTRL_RESET;
        end
    end

    assign port_enable = rcv_ctrl_q[SBRS_RCS_PORT_ENABLE];
    assign nine_bit_receive_select = rcv_ctrl_q[SBRS_RCS_NINE_BIT];
    assign single_receive_enable = rcv_ctrl_q[SBRS_RCS_SINGLE_RX];
    assign continuous_receive_enable = rcv_ctrl_q[SBRS_RCS_CONT_RX];
    assign addr_detect_enable = rcv_ctrl_q[SBRS_RCS_ADDR_DETECT];
    assign clock_source_master = xmt_ctrl_q[SBRS_TCS_CLOCK_SOURCE];
    assign sync_mode = xmt_ctrl_q[SBRS_TCS_SYNC_MODE];
    assign high_speed_select = xmt_ctrl_q[SBRS_TCS_HIGH_SPEED];

    // Continuous receive overrides single receive; single only in sync master
    assign rx_enabled = port_enable && (continuous_receive_enable
        || (sync_mode && clock_source_master && single_receive_enable));
    assign receive_active = rx_enabled && !overrun_error_flag_q;

    // ------------------------------------------------------------------
    // Rate timer: one 8-bit timer for every mode
    // ------------------------------------------------------------------
    sbrs_rate_timer u_rate_timer (
        .clk(clk),
        .rst_n(rst_n),
        .baud_divisor(baud_divisor_q),
        .divisor_write(divisor_write),
        .sync_mode(sync_mode),
        .high_speed_select(high_speed_select),
        .baud_tick(baud_tick)
    );

    // ------------------------------------------------------------------
    // Frame acceptance
    // ------------------------------------------------------------------
    // Address detect only matters in async 9-bit mode
    assign frame_keep = !(addr_detect_enable && nine_bit_receive_select && !sync_mode)
        || rx_shift_register[8];
    // Frames are not stored while overrun stands, as the receiver would be halted
    assign frame_take = frame_valid && receive_active;
    assign fifo_in_valid = frame_take && frame_keep;
    // An address-filtered frame is dropped without needing space
    assign frame_ready = fifo_in_ready || !fifo_in_valid;
    assign frame_overrun = fifo_in_valid && !fifo_in_ready;

    // Ninth bit stored raw; zero in 8-bit mode
    assign fifo_in_data[7:0] = rx_shift_register[7:0];
    assign fifo_in_data[SBRS_ENTRY_NINTH] = nine_bit_receive_select && rx_shift_register[8];
    assign fifo_in_data[SBRS_ENTRY_FRAMING_ERROR_FLAG] = !frame_stop_bit;

    sbrs_fifo #(
        .WIDTH(SBRS_ENTRY_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(rx_data_buffer)
    );

    // Overrun: set wins over the clear done by dropping continuous receive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overrun_error_flag_q <= 1'b0;
        end else if (frame_overrun) begin
            overrun_error_flag_q <= 1'b1;
        end else if (!continuous_receive_enable) begin
            overrun_error_flag_q <= 1'b0;
        end
    end

    // Flags track the entry at the buffer head, so software reads them first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            framing_error_flag_q <= 1'b0;
            rx_ninth_bit_q <= 1'b0;
        end else if (fifo_out_valid) begin
            framing_error_flag_q <= rx_data_buffer[SBRS_ENTRY_FRAMING_ERROR_FLAG];
            rx_ninth_bit_q <= rx_data_buffer[SBRS_ENTRY_NINTH];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_read = s_axi_arvalid && s_axi_arready;
    // Reading the data buffer pops it; an empty buffer reads zero
    assign fifo_out_ready = do_read && addr_is(s_axi_araddr, SBRS_RX_DATA_BUFFER_ADDR);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= SBRS_RESP_OKAY;
        end else if (do_read) begin
            rvalid_q <= 1'b1;
            rresp_q <= addr_known(s_axi_araddr) ? SBRS_RESP_OKAY : SBRS_RESP_SLVERR;
            rdata_q <= '0;
            if (addr_is(s_axi_araddr, SBRS_RCV_STAT_CTRL_ADDR)) begin
                rdata_q[7:0] <= {rcv_ctrl_q[7:3], framing_error_flag_q,
                    overrun_error_flag_q, rx_ninth_bit_q};
            end else if (addr_is(s_axi_araddr, SBRS_BAUD_DIVISOR_ADDR)) begin
                rdata_q[7:0] <= baud_divisor_q;
            end else if (addr_is(s_axi_araddr, SBRS_XMT_STAT_CTRL_ADDR)) begin
                rdata_q[7:0] <= xmt_ctrl_q;
            end else if (addr_is(s_axi_araddr, SBRS_RX_DATA_BUFFER_ADDR)) begin
                rdata_q[7:0] <= fifo_out_valid ? rx_data_buffer[7:0] : 8'h00;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // sbrs_top

// *** sbrs_pkg.sv ***
// Shared constants for the serial baud generator and receive status block
package sbrs_pkg;

    // Register byte addresses
    localparam logic [7:0] SBRS_RCV_STAT_CTRL_ADDR = 8'h00;
    localparam logic [7:0] SBRS_BAUD_DIVISOR_ADDR = 8'h04;
    localparam logic [7:0] SBRS_XMT_STAT_CTRL_ADDR = 8'h08;
    localparam logic [7:0] SBRS_RX_DATA_BUFFER_ADDR = 8'h0C;

    // Reset values
    localparam logic [7:0] SBRS_RCV_STAT_CTRL_RESET = 8'h00;
    localparam logic [7:0] SBRS_BAUD_DIVISOR_RESET = 8'h00;
    localparam logic [7:0] SBRS_XMT_STAT_CTRL_RESET = 8'h02;

    // Receive status and control fields
    localparam int SBRS_RCS_PORT_ENABLE = 7;
    localparam int SBRS_RCS_NINE_BIT = 6;
    localparam int SBRS_RCS_SINGLE_RX = 5;
    localparam int SBRS_RCS_CONT_RX = 4;
    localparam int SBRS_RCS_ADDR_DETECT = 3;
    localparam int SBRS_RCS_FRAMING_ERR = 2;
    localparam int SBRS_RCS_OVERRUN_ERR = 1;
    localparam int SBRS_RCS_NINTH_BIT = 0;
    localparam logic [7:0] SBRS_RCS_WRITE_MASK = 8'hF8;

    // Transmit status and control fields
    localparam int SBRS_TCS_CLOCK_SOURCE = 7;
    localparam int SBRS_TCS_SYNC_MODE = 4;
    localparam int SBRS_TCS_HIGH_SPEED = 2;
    localparam int SBRS_TCS_SHIFT_EMPTY = 1;
    localparam logic [7:0] SBRS_TCS_WRITE_MASK = 8'hF5;

    // Prescale figures, and each as a terminal count (prescale minus one)
    localparam int SBRS_PRESCALE_ASYNC_NORMAL = 64;
    localparam int SBRS_PRESCALE_ASYNC_HIGH = 16;
    localparam int SBRS_PRESCALE_SYNC = 4;
    localparam logic [5:0] SBRS_PRESC_LAST_NORMAL = 6'(SBRS_PRESCALE_ASYNC_NORMAL - 1);
    localparam logic [5:0] SBRS_PRESC_LAST_HIGH = 6'(SBRS_PRESCALE_ASYNC_HIGH - 1);
    localparam logic [5:0] SBRS_PRESC_LAST_SYNC = 6'(SBRS_PRESCALE_SYNC - 1);

    // Receive FIFO entry: {framing error, ninth bit, data byte}
    localparam int SBRS_ENTRY_WIDTH = 10;
    localparam int SBRS_ENTRY_NINTH = 8;
    localparam int SBRS_ENTRY_FRAMING_ERROR_FLAG = 9;
    localparam int SBRS_FIFO_DEPTH = 16;

    // AXI4-Lite responses
    localparam logic [1:0] SBRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBRS_RESP_SLVERR = 2'h2;

endpackage

// *** sbrs_fifo.sv ***
// Receive FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module sbrs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic pop_mem;

    assign in_ready = count_q < (PW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    // Output stage refills when empty or being drained
    assign pop_mem = (count_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop_mem) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop_mem);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (pop_mem) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end
endmodule // sbrs_fifo

// *** sbrs_rate_timer.sv ***
// Free-running baud rate timer with mode-dependent prescale
`timescale 1ns/1ps
module sbrs_rate_timer
    import sbrs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] baud_divisor,
    input wire logic divisor_write,
    input wire logic sync_mode,
    input wire logic high_speed_select,
    output logic baud_tick
);
    logic [5:0] presc_q;
    logic [7:0] rate_q;
    logic tick_q;
    logic [5:0] presc_last;

    function automatic logic [5:0] prescale_last(input logic sync, input logic high);
        if (sync) begin
            return SBRS_PRESC_LAST_SYNC;
        end
        return high ? SBRS_PRESC_LAST_HIGH : SBRS_PRESC_LAST_NORMAL;
    endfunction

    assign presc_last = prescale_last(sync_mode, high_speed_select);
    assign baud_tick = tick_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            presc_q <= '0;
            rate_q <= '0;
            tick_q <= 1'b0;
        end else if (divisor_write) begin
            presc_q <= '0;
            rate_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            // A mode change may leave the count past the new end
            if (presc_q >= presc_last) begin
                presc_q <= '0;
                if (rate_q >= baud_divisor) begin
                    rate_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    rate_q <= rate_q + 8'h01;
                end
            end else begin
                presc_q <= presc_q + 6'h01;
            end
        end
    end
endmodule // sbrs_rate_timer

// *** sbrs_top_sva.sv ***
// Port checker for the serial baud and receive status block
`timescale 1ns/1ps
module sbrs_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic baud_tick,
    input wire logic receive_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    // Both channels are held one cycle before the write lands and bvalid rises
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_data_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_tick_pulse: assert property (baud_tick |=> !baud_tick)
        else $error("rate tick longer than one cycle");
    a_overrun_stop: assert property (frame_valid && receive_active && !frame_ready
        |=> !receive_active)
        else $error("receiver still active after overrun");
    a_refuse_cause: assert property (!frame_ready |-> frame_valid && receive_active)
        else $error("frame refused without a frame");
endmodule // sbrs_top_sva

bind sbrs_top sbrs_top_sva u_sva (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frame_valid,
    .frame_ready, .baud_tick, .receive_active);

// *** sbrs_serial_node.sv ***
// Remote serial node model handing completed frames to the receiver
`timescale 1ns/1ps
module sbrs_serial_node (
    input wire logic clk,
    output logic frame_valid,
    output logic [8:0] rx_shift_register,
    output logic frame_stop_bit
);
    initial begin
        frame_valid = 1'b0;
        rx_shift_register = 9'h1A5;
        frame_stop_bit = 1'b1;
    end

    // Lines flip after the frame so a late sample cannot match
    task automatic send_frame(input logic [8:0] bits, input logic stop);
        @(posedge clk);
        frame_valid <= 1'b1;
        rx_shift_register <= bits;
        frame_stop_bit <= stop;
        @(posedge clk);
        frame_valid <= 1'b0;
        rx_shift_register <= ~bits;
        frame_stop_bit <= ~stop;
    endtask
endmodule // sbrs_serial_node

// *** sbrs_top_tb.sv ***
// Self-checking bench for the serial baud and receive status block
`timescale 1ns/1ps
module sbrs_top_tb;
    import sbrs_pkg::*;
    localparam logic [7:0] A_RCS = SBRS_RCV_STAT_CTRL_ADDR;
    localparam logic [7:0] A_DIV = SBRS_BAUD_DIVISOR_ADDR;
    localparam logic [7:0] A_XMT = SBRS_XMT_STAT_CTRL_ADDR;
    localparam logic [7:0] A_BUF = SBRS_RX_DATA_BUFFER_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic frame_valid, frame_ready, frame_stop_bit, baud_tick, receive_active;
    logic port_enable, sync_mode, nine_bit_receive_select;
    logic [8:0] rx_shift_register;
    int n_errors = 0;
    int checked = 0;
    int n_refused = 0;

    initial forever #50 clk = ~clk;

    sbrs_top #(.ADDR_WIDTH(8), .FIFO_DEPTH(SBRS_FIFO_DEPTH)) DUT (.clk, .rst_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .frame_valid, .frame_ready, .rx_shift_register,
        .frame_stop_bit, .baud_tick, .port_enable, .sync_mode,
        .nine_bit_receive_select, .receive_active);

    sbrs_serial_node node (.clk, .frame_valid, .rx_shift_register, .frame_stop_bit);

    always @(posedge clk) begin
        if (frame_valid && frame_ready === 1'b0) n_refused++;
    end

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic hang(input string name);
        n_errors++;
        $display("BAD %s expected answer seen timeout", name);
        complete_run();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = SBRS_RESP_OKAY);
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 100) hang("write");
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = SBRS_RESP_OKAY);
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 100) hang(n);
        s_axi_rready <= 1'b0;
        chk(n, e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // Gaps let the flags settle onto the buffer head
    task automatic frm(input logic [8:0] d, input logic stop);
        node.send_frame(d, stop);
        repeat (4) @(posedge clk);
    endtask

    task automatic gap(output int n);
        for (n = 1; n < 20000; n++) begin
            @(posedge clk);
            if (baud_tick) return;
        end
        hang("tick");
    endtask

    task automatic t_regs;
        rd("rcs reset", A_RCS, 32'h00);
        rd("div reset", A_DIV, 32'h00);
        rd("xmt reset", A_XMT, 32'h02);
        rd("empty buffer", A_BUF, 32'h00);
        rd("unmapped", 8'h10, 32'h00, SBRS_RESP_SLVERR);
        wr(8'h10, 32'hFF, SBRS_RESP_SLVERR);
        wr(A_XMT, 32'hFFFF_FFFF);
        rd("xmt mask", A_XMT, 32'hF7);
        wr(A_DIV, 32'hFFFF_FF5A);
        rd("div width", A_DIV, 32'h5A);
        $display("t_regs done");
    endtask

    task automatic t_rate;
        logic [7:0] mode [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
        int pre [4] = '{64, 16, 4, 4};
        int n;
        wr(A_DIV, 32'h02);
        for (int k = 0; k < 4; k++) begin
            wr(A_XMT, 32'(mode[k]));
            gap(n);
            gap(n);
            chk("tick period", 32'(pre[k] * 3), 32'(n));
        end
        wr(A_XMT, 32'h00);
        wr(A_DIV, 32'h00);
        gap(n);
        repeat (20) @(posedge clk);
        wr(A_DIV, 32'h00);
        gap(n);
        chk("restart", 32'h1, 32'(n >= 60 && n <= 66));
        $display("t_rate done");
    endtask

    task automatic t_frames;
        wr(A_RCS, 32'hD8);
        frm(9'h0AA, 1'b1);
        frm(9'h155, 1'b1);
        rd("addr flags", A_RCS, 32'hD9);
        rd("addr byte", A_BUF, 32'h55);
        rd("addr dropped", A_BUF, 32'h00);
        wr(A_RCS, 32'hD0);
        frm(9'h0AA, 1'b0);
        rd("frame err", A_RCS, 32'hD4);
        rd("raw byte", A_BUF, 32'hAA);
        frm(9'h1CC, 1'b1);
        rd("ninth kept", A_RCS, 32'hD1);
        rd("raw byte", A_BUF, 32'hCC);
        wr(A_RCS, 32'h98);
        frm(9'h0AA, 1'b1);
        frm(9'h1BB, 1'b1);
        rd("8bit byte", A_BUF, 32'hAA);
        rd("8bit flags", A_RCS, 32'h98);
        rd("8bit byte", A_BUF, 32'hBB);
        // Sync master single receive: one frame taken, address detect ignored
        wr(A_XMT, 32'h90);
        chk("sync pin", 32'h1, 32'(sync_mode));
        wr(A_RCS, 32'hE8);
        chk("rx pins", 32'h3, 32'({port_enable, nine_bit_receive_select}));
        frm(9'h042, 1'b1);
        frm(9'h033, 1'b1);
        rd("single clr", A_RCS, 32'hC8);
        rd("sync byte", A_BUF, 32'h42);
        rd("single once", A_BUF, 32'h00);
        wr(A_XMT, 32'h00);
        chk("sync pin off", 32'h0, 32'(sync_mode));
        $display("t_frames done");
    endtask

    task automatic t_over;
        wr(A_RCS, 32'h90);
        for (int i = 0; i < SBRS_FIFO_DEPTH + 2; i++) node.send_frame(9'(i), 1'b1);
        repeat (4) @(posedge clk);
        chk("refused", 32'h1, 32'(n_refused));
        chk("active", 32'h0, 32'(receive_active));
        rd("overrun", A_RCS, 32'h92);
        for (int i = 0; i <= SBRS_FIFO_DEPTH; i++) rd("drain", A_BUF, 32'(i));
        rd("drained", A_BUF, 32'h00);
        rd("overrun kept", A_RCS, 32'h92);
        wr(A_RCS, 32'h80);
        rd("overrun clear", A_RCS, 32'h80);
        wr(A_RCS, 32'h90);
        frm(9'h077, 1'b1);
        rd("resumed", A_BUF, 32'h77);
        $display("t_over done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_rate();
        t_frames();
        t_over();
        complete_run();
    end
endmodule // sbrs_top_tb
